// File: core/adcsq_pkg.sv
package adcsq_pkg;

  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_RES_HI = 10'h01E;
  localparam logic [9:0] IDX_CTRL0 = 10'h01F;
  localparam logic [9:0] IDX_IRQ = 10'h020;
  localparam logic [9:0] IDX_RES_LO = 10'h09E;
  localparam logic [9:0] IDX_CTRL1 = 10'h09F;

  // Main control fields
  localparam int C0_CLK_LSB = 6;
  localparam int C0_CHAN_LSB = 3;
  localparam int C0_GO_BIT = 2;
  localparam int C0_PWR_BIT = 0;
  localparam logic [7:0] C0_MASK = 8'hFD;

  // Port configuration fields
  localparam int C1_FMT_BIT = 7;
  localparam int C1_HALVE_BIT = 6;
  localparam int C1_PCFG_LSB = 0;
  localparam logic [7:0] C1_MASK = 8'hCF;

  // Interrupt control fields
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_ENA_BIT = 1;
  localparam int IRQ_GIE_BIT = 2;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] RES_RST = 16'h0000;

  // Conversion timing in conversion clock periods
  localparam logic [3:0] CONV_TADS = 4'h9;
  localparam logic [3:0] HOLD_TADS = 4'h2;

  // Clock select code that picks the internal RC oscillator
  localparam logic [1:0] CLK_SEL_RC = 2'h3;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register select codes
  typedef enum logic [2:0] {
    SEL_NONE, SEL_CTRL0, SEL_CTRL1, SEL_IRQ, SEL_RES_HI, SEL_RES_LO
  } adcsq_sel_e;

  // Sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_HOLD} adcsq_state_e;

  // Pin configuration: analog map an4..an0 and external references
  typedef struct packed {
    logic [4:0] analog;
    logic vref_pos_ext;
    logic vref_neg_ext;
  } adcsq_pins_s;

  localparam adcsq_pins_s PINS_RST = '{analog: 5'h1F, vref_pos_ext: 1'b0, vref_neg_ext: 1'b0};

endpackage : adcsq_pkg

// File: core/adcsq_tad_gen.sv
`timescale 1ns/1ps
`default_nettype none
module adcsq_tad_gen
  import adcsq_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic run,
  input wire logic [1:0] clk_sel,
  input wire logic halve,
  // Internal RC oscillator pin
  input wire logic rc_clk,
  // One cycle per conversion clock period
  output logic tick
);

  typedef struct packed {
    logic [5:0] cnt;
    logic rc_s1;
    logic rc_s2;
    logic rc_s3;
    logic tick;
  } adcsq_tad_s;

  adcsq_tad_s tad_reg;
  adcsq_tad_s tad_next;
  logic [5:0] last;

  // Divide by 2 shifted left by two per code step, plus one when halved
  always_comb begin
    last = 6'((7'h02 << {clk_sel, 1'b0} << halve) - 7'h01);
    tad_next = tad_reg;
    tad_next.rc_s1 = rc_clk;
    tad_next.rc_s2 = tad_reg.rc_s1;
    tad_next.rc_s3 = tad_reg.rc_s2;
    tad_next.tick = 1'b0;
    if (!run) begin
      tad_next.cnt = 6'h00;
    end else if (clk_sel == CLK_SEL_RC) begin
      // (R17) RC clock source
      tad_next.tick = tad_reg.rc_s2 & ~tad_reg.rc_s3;
    end else if (tad_reg.cnt == last) begin
      // (R1) (R2) system clock divide
      tad_next.cnt = 6'h00;
      tad_next.tick = 1'b1;
    end else begin
      tad_next.cnt = tad_reg.cnt + 6'h01;
    end
  end

  // Register stage; the RC pin passes two flops before the edge detect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tad_reg <= '0;
    end else begin
      tad_reg <= tad_next;
    end
  end

  assign tick = tad_reg.tick;

endmodule : adcsq_tad_gen
`default_nettype wire

// File: core/adcsq_port_decode.sv
`timescale 1ns/1ps
`default_nettype none
module adcsq_port_decode
  import adcsq_pkg::*;
(
  // Port configuration field
  input wire logic [3:0] pcfg,
  // Decoded pin roles
  output adcsq_pins_s pins
);

  // (R10) analog digital map
  always_comb begin
    unique case (pcfg)
      4'h0, 4'h2, 4'h9: pins.analog = 5'h1F;
      4'h1, 4'h3, 4'hA: pins.analog = 5'h17;
      4'h4: pins.analog = 5'h0B;
      4'h5, 4'hD: pins.analog = 5'h03;
      4'h6, 4'h7: pins.analog = 5'h00;
      4'h8, 4'hB, 4'hC: pins.analog = 5'h13;
      4'hE, 4'hF: pins.analog = 5'h01;
    endcase
    // (R11) reference selection
    unique case (pcfg)
      4'h1, 4'h3, 4'h5, 4'hA: pins.vref_pos_ext = 1'b1;
      4'h8, 4'hB, 4'hC, 4'hD, 4'hF: pins.vref_pos_ext = 1'b1;
      default: pins.vref_pos_ext = 1'b0;
    endcase
    unique case (pcfg)
      4'h8, 4'hB, 4'hC, 4'hD, 4'hF: pins.vref_neg_ext = 1'b1;
      default: pins.vref_neg_ext = 1'b0;
    endcase
  end

endmodule : adcsq_port_decode
`default_nettype wire

// File: core/adcsq_top.sv
// What this block does
// (R1) Halve off: clock codes 00,01,10 give sysclk/2,/8,/32; 11 is RC.
// (R2) Halve on: codes 00,01,10 give /4,/16,/64; 11 still RC.
// (R3) Channel field 000..100 routes input 0..4 to the converter.
// (R4) Writing status bit 1 while powered starts; it reads 1 while busy.
// (R5) Completion loads result, clears status bit, sets done flag together.
// (R6) Power bit 1 runs converter; 0 shuts it off.
// (R7) Both control registers reset to zero; unimplemented bits read zero.
// (R8) Format 1 right-justifies; upper six bits of high byte are zero.
// (R9) Format 0 left-justifies; lower six bits of low byte are zero.
// (R10) Port field decodes each of five pins as analog or digital.
// (R11) Port field picks input 3 / input 2 references, else supply rails.
// (R12) Each conversion yields a 10-bit unsigned result.
// (R13) Hold capacitor stays disconnected two conversion periods after a conversion.
// (R14) Software waits two periods plus acquisition before next start.
// (R15) Software waits acquisition time after changing channel.
// (R16) Software configures pins, channel, clock, power, interrupt, then starts.
// (R17) Sleep conversions need RC clock; converter then runs from it.
// (R18) A conversion takes nine conversion clock periods.
// (R19) Clearing status bit mid-conversion aborts; result keeps old value.
// (R20) Reset disables, aborts, and makes all inputs analog.
// (R21) Done flag stays until cleared; request needs enable and global enable.
`timescale 1ns/1ps
`default_nettype none
module adcsq_top
  import adcsq_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog front end
  input wire logic rc_osc_clk,
  input wire logic [9:0] sample_level,
  output logic [2:0] channel_select,
  output logic hold_connected,
  output logic converter_on,
  // Pin configuration
  output adcsq_pins_s pin_config,
  // Interrupt request
  output logic irq_req
);

  typedef struct packed {
    logic [7:0] c0;
    logic [7:0] c1;
    logic flag;
    logic ena;
    logic global_interrupt_enable;
    logic [15:0] res;
    adcsq_state_e st;
    logic [3:0] tads;
    logic aw_rdy;
    logic aw_ok;
    logic [ADDR_W-1:0] aw_addr;
    logic w_rdy;
    logic w_ok;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [9:0] samp1;
    logic [9:0] samp2;
    adcsq_pins_s pins;
    logic [2:0] chan;
    logic hold;
    logic irq;
  } adcsq_state_s;

  adcsq_state_s st_reg;
  adcsq_state_s st_next;
  logic tick;
  adcsq_pins_s pins_dec;

  // Address decode shared by the read and write paths
  function automatic adcsq_sel_e reg_sel(input logic [ADDR_W-1:0] a);
    adcsq_sel_e s;
    s = SEL_NONE;
    if (a[1:0] == 2'h0) begin
      unique case (a[ADDR_W-1:2])
        IDX_CTRL0: s = SEL_CTRL0;
        IDX_CTRL1: s = SEL_CTRL1;
        IDX_IRQ: s = SEL_IRQ;
        IDX_RES_HI: s = SEL_RES_HI;
        IDX_RES_LO: s = SEL_RES_LO;
        default: s = SEL_NONE;
      endcase
    end
    return s;
  endfunction : reg_sel

  // Conversion clock; its divider restarts at every start so the first period is whole, except with the RC source
  adcsq_tad_gen adcsq_tad_gen_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(st_reg.st != ST_IDLE),
    .clk_sel(st_reg.c0[C0_CLK_LSB+:2]),
    .halve(st_reg.c1[C1_HALVE_BIT]),
    .rc_clk(rc_osc_clk),
    .tick(tick)
  );

  // Pin role decoder
  adcsq_port_decode adcsq_port_decode_inst (
    .pcfg(st_reg.c1[C1_PCFG_LSB+:4]),
    .pins(pins_dec)
  );

  // Next-state logic for bus, registers and sequencer
  always_comb begin
    logic [7:0] wd;
    logic go_w;
    logic pwr_w;
    wd = st_reg.w_data;
    go_w = wd[C0_GO_BIT];
    pwr_w = wd[C0_PWR_BIT];
    st_next = st_reg;

    // Sample level crosses into this domain through two flops
    st_next.samp1 = sample_level;
    st_next.samp2 = st_reg.samp1;

    // Response handshakes retire first so a slot frees at once
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end

    // Address and data are taken independently, in either order
    if (s_axi_awvalid && st_reg.aw_rdy) begin
      st_next.aw_ok = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.w_rdy) begin
      st_next.w_ok = 1'b1;
      st_next.w_data = s_axi_wdata[7:0];
      st_next.w_lane0 = s_axi_wstrb[0];
    end

    // Write is performed once both halves are held
    if (st_reg.aw_ok && st_reg.w_ok && !st_reg.bvalid) begin
      st_next.aw_ok = 1'b0;
      st_next.w_ok = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      unique case (reg_sel(st_reg.aw_addr))
        SEL_CTRL0: begin
          if (st_reg.w_lane0) begin
            // (R7) unimplemented bit masked
            st_next.c0 = wd & C0_MASK;
            if (st_reg.st == ST_CONV) begin
              // (R19) abort on clear
              if (!go_w || !pwr_w) begin
                st_next.st = ST_HOLD;
                st_next.tads = 4'h0;
              end
            end else if (go_w && pwr_w && st_reg.c0[C0_PWR_BIT] &&
                         st_reg.st == ST_IDLE) begin
              // (R4) start conversion
              st_next.st = ST_CONV;
              st_next.tads = 4'h0;
            end else begin
              // A start while off, or during the hold gap, is dropped
              st_next.c0[C0_GO_BIT] = 1'b0;
            end
          end
        end
        SEL_CTRL1: begin
          if (st_reg.w_lane0) begin
            st_next.c1 = wd & C1_MASK;
          end
        end
        SEL_IRQ: begin
          if (st_reg.w_lane0) begin
            st_next.flag = wd[IRQ_FLAG_BIT];
            st_next.ena = wd[IRQ_ENA_BIT];
            st_next.global_interrupt_enable = wd[IRQ_GIE_BIT];
          end
        end
        SEL_RES_HI: begin
          if (st_reg.w_lane0) begin
            st_next.res[15:8] = wd;
          end
        end
        SEL_RES_LO: begin
          if (st_reg.w_lane0) begin
            st_next.res[7:0] = wd;
          end
        end
        SEL_NONE: begin
          st_next.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Read returns live register state; reads have no side effects
    if (s_axi_arvalid && st_reg.ar_rdy) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      st_next.rdata = '0;
      unique case (reg_sel(s_axi_araddr))
        SEL_CTRL0: st_next.rdata[7:0] = st_reg.c0;
        SEL_CTRL1: st_next.rdata[7:0] = st_reg.c1;
        SEL_IRQ: st_next.rdata[2:0] = {st_reg.global_interrupt_enable, st_reg.ena, st_reg.flag};
        SEL_RES_HI: st_next.rdata[7:0] = st_reg.res[15:8];
        SEL_RES_LO: st_next.rdata[7:0] = st_reg.res[7:0];
        SEL_NONE: st_next.rresp = RESP_SLVERR;
      endcase
    end

    // Sequencer runs on conversion clock ticks
    if (tick) begin
      unique case (st_reg.st)
        ST_CONV: begin
          if (st_reg.tads == CONV_TADS - 4'h1) begin
            // (R18) nine periods done
            // (R5) completion event
            st_next.st = ST_HOLD;
            st_next.tads = 4'h0;
            st_next.c0[C0_GO_BIT] = 1'b0;
            // (R21) flag set wins
            st_next.flag = 1'b1;
            // (R12) 10-bit capture
            if (st_reg.c1[C1_FMT_BIT]) begin
              // (R8) right justify
              st_next.res = {6'h00, st_reg.samp2};
            end else begin
              // (R9) left justify
              st_next.res = {st_reg.samp2, 6'h00};
            end
          end else if (st_next.st == ST_CONV) begin
            // An abort in this cycle keeps its zero count for the hold gap
            st_next.tads = st_reg.tads + 4'h1;
          end
        end
        ST_HOLD: begin
          // (R13) hold gap count
          if (st_reg.tads == HOLD_TADS - 4'h1) begin
            st_next.st = ST_IDLE;
          end else begin
            st_next.tads = st_reg.tads + 4'h1;
          end
        end
        ST_IDLE: begin
          st_next.tads = 4'h0;
        end
      endcase
    end

    // (R6) power off stops all
    if (!st_next.c0[C0_PWR_BIT]) begin
      st_next.st = ST_IDLE;
      st_next.c0[C0_GO_BIT] = 1'b0;
    end

    // Ready flags are registered so the bus outputs come from flops
    st_next.aw_rdy = !st_next.aw_ok && !st_next.bvalid;
    st_next.w_rdy = !st_next.w_ok && !st_next.bvalid;
    st_next.ar_rdy = !st_next.rvalid;

    // Registered pin side outputs
    // (R3) channel routing
    st_next.chan = st_next.c0[C0_CHAN_LSB+:3];
    st_next.pins = pins_dec;
    // (R13) hold disconnect
    st_next.hold = st_next.c0[C0_PWR_BIT] && (st_next.st != ST_HOLD);
    // (R21) gated request
    st_next.irq = st_next.flag && st_next.ena && st_next.global_interrupt_enable;
  end

  // State register; pin map resets to all analog
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // (R20) reset abort
      st_reg <= '0;
      st_reg.c0 <= CTRL_RST;
      st_reg.c1 <= CTRL_RST;
      st_reg.res <= RES_RST;
      st_reg.st <= ST_IDLE;
      st_reg.pins <= PINS_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = st_reg.aw_rdy;
  assign s_axi_wready = st_reg.w_rdy;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_arready = st_reg.ar_rdy;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign channel_select = st_reg.chan;
  assign hold_connected = st_reg.hold;
  assign converter_on = st_reg.c0[C0_PWR_BIT];
  assign pin_config = st_reg.pins;
  assign irq_req = st_reg.irq;

endmodule : adcsq_top
`default_nettype wire

// File: dv/adcsq_properties.sv
`timescale 1ns/1ps
`default_nettype none
module adcsq_properties
  import adcsq_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_bresp,
  // Converter side
  input wire logic hold_connected,
  input wire logic converter_on,
  input wire logic irq_req,
  input wire adcsq_pins_s pin_config
);
  // One domain, so one clock and reset serve all
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_pins_after_reset: assert property ($rose(aresetn) |-> pin_config == PINS_RST)
    else $error("pin roles wrong after reset");
  chk_an0_digital: assert property (!pin_config.analog[0] |-> pin_config.analog == 5'h00)
    else $error("input 0 digital but others analog");
  chk_vref_pair: assert property (pin_config.vref_neg_ext |-> pin_config.vref_pos_ext)
    else $error("negative reference without positive");
  chk_hold_gap: assert property ($fell(hold_connected) && converter_on |=> !hold_connected [*2])
    else $error("hold gap too short");
  chk_power_hold: assert property ($fell(converter_on) |-> ##1 !hold_connected)
    else $error("hold connected while powered off");
  chk_rdata_upper: assert property ($rose(s_axi_rvalid) |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  chk_rvalid_drop: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("read answer dropped early");
  chk_bvalid_drop: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("write answer dropped early");
  chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answering");

  // Main scenarios reached
  cover property ($fell(hold_connected));
  cover property ($rose(irq_req));
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : adcsq_properties
`default_nettype wire

// File: dv/adcsq_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adcsq_top_bench
  import adcsq_pkg::*;
;
  localparam logic [11:0] ad_c0 = {IDX_CTRL0, 2'h0};
  localparam logic [11:0] ad_c1 = {IDX_CTRL1, 2'h0};
  localparam logic [11:0] ad_hi = {IDX_RES_HI, 2'h0};
  localparam logic [11:0] ad_lo = {IDX_RES_LO, 2'h0};
  localparam logic [11:0] ad_irq = {IDX_IRQ, 2'h0};
  // Inputs, all valued at time zero; prot tied, strobes driven low once by the register test
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic rc_osc_clk = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [2:0] s_axi_awprot = 3'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic [9:0] sample_level = 10'h000;
  // Outputs
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic hold_connected, converter_on, irq_req;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [2:0] channel_select;
  adcsq_pins_s pin_config;
  int checks = 0;
  int fails = 0;
  int cyc = 0;
  logic [15:0] last;

  adcsq_top adcsq_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rc_osc_clk, .sample_level,
    .channel_select, .hold_connected, .converter_on, .pin_config, .irq_req);

  // 125 MHz system clock
  initial begin
    forever #4 aclk = ~aclk;
  end
  // RC oscillator at ten system periods, phase unrelated
  initial begin
    #3;
    forever #40 rc_osc_clk = ~rc_osc_clk;
  end

  task automatic report_and_stop;
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // Ceiling well above the longest conversion sweep
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] r);
    logic ad;
    logic dd;
    ad = 1'h0;
    dd = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1 && !ad) begin
        ad = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wready === 1'h1 && !dd) begin
        dd = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd

  task automatic wait_hold(input logic v);
    while (hold_connected !== v) @(posedge aclk);
  endtask : wait_hold

  task automatic check_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd(ad_c0, d, r);
    cmp("ctrl0", 32'h0, d);
    rd(ad_c1, d, r);
    cmp("ctrl1", 32'h0, d);
    // Unused bits stay zero; start refused while off
    wr(ad_c1, 32'hFF, r);
    rd(ad_c1, d, r);
    cmp("ctrl1", 32'hCF, d);
    // Lane 0 strobe low leaves the register untouched
    s_axi_wstrb <= 4'h0;
    wr(ad_c1, 32'h00, r);
    s_axi_wstrb <= 4'hF;
    rd(ad_c1, d, r);
    cmp("ctrl1", 32'hCF, d);
    wr(ad_c0, 32'h06, r);
    rd(ad_c0, d, r);
    cmp("ctrl0", 32'h0, d);
    wr(12'h004, 32'h1, r);
    cmp("bresp", 32'(RESP_SLVERR), 32'(r));
    rd(12'h004, d, r);
    cmp("rresp", 32'(RESP_SLVERR), 32'(r));
  endtask : check_regs

  // Reference pins masked out, as their analog bit is not defined
  task automatic check_pins;
    logic [6:0] tb [16] = '{7'h7C, 7'h5E, 7'h7C, 7'h5E, 7'h2C, 7'h0E, 7'h00, 7'h00,
      7'h4F, 7'h7C, 7'h5E, 7'h4F, 7'h4F, 7'h0F, 7'h04, 7'h07};
    logic [1:0] r;
    adcsq_pins_s p;
    for (int i = 0; i < 16; i++) begin
      wr(ad_c1, 32'(i), r);
      repeat (3) @(posedge aclk);
      p = pin_config;
      cmp("pins", 32'(tb[i]), 32'({p.analog & ~{1'h0, p.vref_pos_ext, p.vref_neg_ext, 2'h0},
        p.vref_pos_ext, p.vref_neg_ext}));
    end
  endtask : check_pins

  task automatic conv_run(input logic [1:0] c, input logic h);
    int dv;
    int t0;
    logic [2:0] ch;
    logic [9:0] s;
    logic [15:0] e;
    logic [31:0] d;
    logic [1:0] r;
    dv = (c == 2'h3) ? 10 : (2 << (2 * c)) << h;
    ch = 3'(c) + 3'(h);
    s = {1'h1, c, h, 3'h5, c, h};
    e = c[0] ? {6'h00, s} : {s, 6'h00};
    sample_level <= s;
    // pins and format first, then channel, clock and power
    wr(ad_c1, {24'h0, c[0], h, 6'h00}, r);
    wr(ad_c0, {24'h0, c, ch, 3'h1}, r);
    repeat (2) @(posedge aclk);
    cmp("channel", 32'(ch), 32'(channel_select));
    wait_hold(1'h1);
    // acquisition time on the new channel
    repeat (20) @(posedge aclk);
    wr(ad_c0, {24'h0, c, ch, 3'h5}, r);
    t0 = cyc;
    rd(ad_c0, d, r);
    cmp("busy", 32'h1, 32'(d[2]));
    wait_hold(1'h0);
    cmp("conv_time", 32'h1, 32'(cyc - t0 >= 8 * dv && cyc - t0 <= 9 * dv + 4));
    repeat (2) @(posedge aclk);
    cmp("irq", 32'h1, 32'(irq_req));
    rd(ad_hi, d, r);
    cmp("res_hi", 32'(e[15:8]), d);
    rd(ad_lo, d, r);
    cmp("res_lo", 32'(e[7:0]), d);
    rd(ad_c0, d, r);
    cmp("ctrl0", 32'({c, ch, 3'h1}), d);
    rd(ad_irq, d, r);
    cmp("flag", 32'h7, d);
    wr(ad_irq, 32'h6, r);
    repeat (2) @(posedge aclk);
    cmp("irq", 32'h0, 32'(irq_req));
    wait_hold(1'h1);
    last = e;
  endtask : conv_run

  task automatic check_abort;
    logic [31:0] d;
    logic [1:0] r;
    sample_level <= 10'h0F0;
    wr(ad_c0, 32'hA5, r);
    wr(ad_c0, 32'hA1, r);
    // Past the point where nine periods at divide 64 would land
    repeat (600) @(posedge aclk);
    rd(ad_hi, d, r);
    cmp("res_hi", 32'(last[15:8]), d);
    rd(ad_lo, d, r);
    cmp("res_lo", 32'(last[7:0]), d);
    rd(ad_irq, d, r);
    cmp("flag", 32'h6, d);
    wr(ad_c0, 32'h0, r);
    repeat (2) @(posedge aclk);
    cmp("power", 32'h0, 32'(converter_on));
  endtask : check_abort

  // Main sequence
  initial begin
    logic [1:0] r;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    cmp("pins", 32'(PINS_RST), 32'(pin_config));
    check_regs();
    check_pins();
    wr(ad_irq, 32'h6, r);
    for (int i = 0; i < 8; i++) conv_run(2'(i >> 1), i[0]);
    check_abort();
    report_and_stop();
  end
endmodule : adcsq_top_bench

bind adcsq_top adcsq_properties adcsq_properties_inst (.aclk, .aresetn, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bresp,
  .hold_connected, .converter_on, .irq_req, .pin_config);
`default_nettype wire
